// ==== lcdcdl_map.svh ====
// constants of the column data loader: geometry, bus offsets, fields
// assumes inclusion by bare name from the package and the top module
`ifndef LCDCDL_MAP_SVH
`define LCDCDL_MAP_SVH

// line geometry
`define LCDCDL_COLUMNS 9'h180
`define LCDCDL_WORD_BITS 6
`define LCDCDL_WORDS_PER_EDGE 6
`define LCDCDL_EDGES_PER_LINE 7'h40
`define LCDCDL_LAST_EDGE 6'h3f

// bus register byte offsets
`define LCDCDL_ADR_STATUS 8'h00
`define LCDCDL_ADR_COLSEL 8'h04
`define LCDCDL_ADR_COLDATA 8'h08

// status field positions
`define LCDCDL_ST_OPERATIONAL 0
`define LCDCDL_ST_LOADING 1
`define LCDCDL_ST_FULL 2
`define LCDCDL_ST_BANK 3
`define LCDCDL_ST_COUNT_LO 8
`define LCDCDL_ST_DIR 16
`define LCDCDL_ST_TEST 17

// column data field positions
`define LCDCDL_CD_HIGH_REGION 8
`define LCDCDL_CD_AMP_ENABLE 9

// reset values
`define LCDCDL_RST_COLSEL 9'h000
`define LCDCDL_RST_COUNT 7'h00

`endif

// ==== lcdcdl_pkg.sv ====
// types shared by the column data loader modules
// assumes lcdcdl_map.svh is on the include path
`include "lcdcdl_map.svh"

package lcdcdl_pkg;

  // one column-load-clock beat: six words, first column in the low bits
  typedef struct packed {
    logic [5:0] blue1;
    logic [5:0] green1;
    logic [5:0] red1;
    logic [5:0] blue0;
    logic [5:0] green0;
    logic [5:0] red0;
  } lcdcdl_pixel_t;

  // column index split into latch group and slot within the group
  typedef struct packed {
    logic [5:0] group;
    logic [2:0] slot;
  } lcdcdl_colpos_t;

  typedef enum logic [1:0] {
    IDLE,
    LOAD,
    FULL
  } lcdcdl_state_t;

endpackage

// ==== lcdcdl_line_mem.sv ====
// two-bank line store: one bank loads while the other holds
// assumes single clock; read data appear one edge after the address
`timescale 1ns/1ps
`default_nettype none

module lcdcdl_line_mem #(
  parameter int WIDTH = 36,
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] store [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      store[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rdData <= '0;
    end
    else
    begin
      rdData <= store[rdAddr];
    end
  end

endmodule // lcdcdl_line_mem

`default_nettype wire

// ==== lcdcdl_edge_det.sv ====
// rising edge finder for pins that are synchronous to clk
// rise is combinational so it lines up with data of the same cycle
`timescale 1ns/1ps
`default_nettype none

module lcdcdl_edge_det #(
  parameter int N = 3
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [N-1:0] level,
  output logic [N-1:0] rise
);

  logic [N-1:0] prev_reg;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      prev_reg <= '0;
    end
    else
    begin
      prev_reg <= level;
    end
  end

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_rise
      assign rise[i] = level[i] & ~prev_reg[i];
    end
  endgenerate

endmodule // lcdcdl_edge_det

`default_nettype wire

// ==== lcdcdl_loader.sv ====
// digital front end of a 384-column source driver: start pulse handling,
// six-word beat capture into the data latch, line latch, column readout
// assumes all pins synchronous to clk and a classic wishbone master
//
// What this block does
// - direction high: left start pin in, right out, fill column 1 to 384.
// - direction low: left start pin out, right in, fill column 384 to 1.
// - a start pulse begins loading; a pulse goes out when loading is done.
// - each column clock rise while loading puts six 6-bit words in the next six columns.
// - a line latch strobe rise moves the data latch to the holding stage.
// - after a line latch strobe the loader clears and awaits a new start.
// - outputs are valid only once one line latch strobe has arrived.
// - dot sign high: odd columns use the high region, even ones the low.
// - dot sign low: even columns use the high region, odd ones the low.
// - with data invert high each word is stored complemented.
// - a high test pin cuts the amplifiers off; low is normal operation.
`timescale 1ns/1ps
`default_nettype none
`include "lcdcdl_map.svh"

module lcdcdl_loader #(
  parameter int WORD_BITS = `LCDCDL_WORD_BITS,
  parameter int WORDS = `LCDCDL_WORDS_PER_EDGE
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic shiftDirectionSelect,
  input wire logic startPulseLeftPinIn,
  output logic startPulseLeftPinOut,
  output logic startPulseLeftPinOe,
  input wire logic startPulseRightPinIn,
  output logic startPulseRightPinOut,
  output logic startPulseRightPinOe,
  input wire logic columnLoadClock,
  input wire logic lineLatchStrobe,
  input wire lcdcdl_pkg::lcdcdl_pixel_t pixelPort,
  input wire logic dotSignSelect,
  input wire logic dataInvertSelect,
  input wire logic testPin,
  output logic ampEnable,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  localparam int BEAT = WORD_BITS * WORDS;

  // column index to latch group and slot
  function automatic lcdcdl_pkg::lcdcdl_colpos_t colSplit(
    input logic [8:0] col
  );
    logic [8:0] grp;
    lcdcdl_pkg::lcdcdl_colpos_t pos;
    grp = col / 9'h006;
    pos.group = grp[5:0];
    pos.slot = 3'(col - 9'(grp * 9'h006));
    return pos;
  endfunction

  // pin edge detection
  logic [2:0] pinLevel, pinRise;
  logic startIn, startRise, beatRise, strobeRise;

  // start input follows the live direction select
  assign startIn = shiftDirectionSelect ? startPulseLeftPinIn :
                   startPulseRightPinIn;
  assign pinLevel = {startIn, lineLatchStrobe, columnLoadClock};

  lcdcdl_edge_det #(.N(3)) u_edge (
    .clk(clk),
    .sys_rst(sys_rst),
    .level(pinLevel),
    .rise(pinRise)
  );

  assign beatRise = pinRise[0];
  assign strobeRise = pinRise[1];
  assign startRise = pinRise[2];

  // loader state
  lcdcdl_pkg::lcdcdl_state_t state_reg, state_next;
  logic [6:0] count_reg, count_next;
  logic loadDir_reg, loadBank_reg, operational_reg;
  logic pulse_reg, pulse_next;
  logic writeBeat, lastBeat;

  assign writeBeat = (state_reg == lcdcdl_pkg::LOAD) && beatRise &&
                     !strobeRise;
  assign lastBeat = writeBeat &&
                    (count_reg[5:0] == `LCDCDL_LAST_EDGE);

  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    if (strobeRise)
    begin
      // a strobe always clears the loader, even mid-line
      state_next = lcdcdl_pkg::IDLE;
      count_next = `LCDCDL_RST_COUNT;
    end
    else
    begin
      case (state_reg)
        lcdcdl_pkg::IDLE:
        begin
          if (startRise)
          begin
            // data beats count only from the next clock edge on
            state_next = lcdcdl_pkg::LOAD;
            count_next = `LCDCDL_RST_COUNT;
          end
        end
        lcdcdl_pkg::LOAD:
        begin
          if (writeBeat)
          begin
            count_next = count_reg + 7'h01;
            if (lastBeat)
            begin
              state_next = lcdcdl_pkg::FULL;
            end
          end
        end
        lcdcdl_pkg::FULL:
        begin
          state_next = lcdcdl_pkg::FULL;
        end
        default:
        begin
          state_next = lcdcdl_pkg::IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg <= lcdcdl_pkg::IDLE;
      count_reg <= `LCDCDL_RST_COUNT;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // direction is held per line so a mid-line change cannot scramble it
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      loadDir_reg <= 1'b1;
    end
    else if (state_reg == lcdcdl_pkg::IDLE && startRise && !strobeRise)
    begin
      loadDir_reg <= shiftDirectionSelect;
    end
  end

  // bank swap is the line latch; first strobe makes outputs valid
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      loadBank_reg <= 1'b0;
      operational_reg <= 1'b0;
    end
    else if (strobeRise)
    begin
      loadBank_reg <= ~loadBank_reg;
      operational_reg <= 1'b1;
    end
  end

  // cascade pulse: one column clock period wide; a strobe clear beats its set
  assign pulse_next = !strobeRise &&
                      (lastBeat || (pulse_reg && !beatRise));

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pulse_reg <= 1'b0;
      startPulseLeftPinOut <= 1'b0;
      startPulseRightPinOut <= 1'b0;
      startPulseLeftPinOe <= 1'b0;
      startPulseRightPinOe <= 1'b0;
    end
    else
    begin
      pulse_reg <= pulse_next;
      startPulseRightPinOut <= shiftDirectionSelect & pulse_next;
      startPulseLeftPinOut <= ~shiftDirectionSelect & pulse_next;
      startPulseRightPinOe <= shiftDirectionSelect;
      startPulseLeftPinOe <= ~shiftDirectionSelect;
    end
  end

  // data latch write path
  logic [5:0] beatGroup;
  logic [BEAT-1:0] beatWord, memRdData;
  logic [6:0] memWrAddr, memRdAddr;

  // descending fill takes the last group first
  assign beatGroup = loadDir_reg ? count_reg[5:0] :
                     `LCDCDL_LAST_EDGE - count_reg[5:0];
  assign beatWord = dataInvertSelect ? ~BEAT'(pixelPort) :
                    BEAT'(pixelPort);
  assign memWrAddr = {loadBank_reg, beatGroup};

  // column readout selection
  logic [8:0] colSel_reg;
  lcdcdl_pkg::lcdcdl_colpos_t colPos;
  logic [2:0] rdSlot_reg;
  logic rdValid_reg, highRegion;
  logic [WORD_BITS-1:0] colCode;

  assign colPos = colSplit(colSel_reg);
  // holding bank is the one not being loaded
  assign memRdAddr = {~loadBank_reg, colPos.group};

  lcdcdl_line_mem #(.WIDTH(BEAT), .AW(7)) u_mem (
    .clk(clk),
    .sys_rst(sys_rst),
    .wrEn(writeBeat),
    .wrAddr(memWrAddr),
    .wrData(beatWord),
    .rdAddr(memRdAddr),
    .rdData(memRdData)
  );

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rdSlot_reg <= 3'h0;
      rdValid_reg <= 1'b0;
    end
    else
    begin
      rdSlot_reg <= colPos.slot;
      rdValid_reg <= (colSel_reg < `LCDCDL_COLUMNS);
    end
  end

  assign colCode = rdValid_reg ?
                   memRdData[rdSlot_reg * WORD_BITS +: WORD_BITS] :
                   '0;
  // column index 0 is column number one, an odd column
  assign highRegion = dotSignSelect ? ~colSel_reg[0] :
                      colSel_reg[0];

  // amplifier enable
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ampEnable <= 1'b0;
    end
    else
    begin
      ampEnable <= ~testPin & operational_reg;
    end
  end

  // wishbone slave: ack two edges after the request is seen
  logic busReq, busWait_reg;
  logic [31:0] statusWord, colDataWord, readWord;

  assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_comb
  begin
    statusWord = 32'h0000_0000;
    statusWord[`LCDCDL_ST_OPERATIONAL] = operational_reg;
    statusWord[`LCDCDL_ST_LOADING] = (state_reg == lcdcdl_pkg::LOAD);
    statusWord[`LCDCDL_ST_FULL] = (state_reg == lcdcdl_pkg::FULL);
    statusWord[`LCDCDL_ST_BANK] = loadBank_reg;
    statusWord[`LCDCDL_ST_COUNT_LO +: 7] = count_reg;
    statusWord[`LCDCDL_ST_DIR] = loadDir_reg;
    statusWord[`LCDCDL_ST_TEST] = testPin;
  end

  always_comb
  begin
    colDataWord = 32'h0000_0000;
    colDataWord[WORD_BITS-1:0] = colCode;
    colDataWord[`LCDCDL_CD_HIGH_REGION] = highRegion;
    colDataWord[`LCDCDL_CD_AMP_ENABLE] = ampEnable;
  end

  always_comb
  begin
    if (wb_adr_i == `LCDCDL_ADR_STATUS)
    begin
      readWord = statusWord;
    end
    else if (wb_adr_i == `LCDCDL_ADR_COLSEL)
    begin
      readWord = {23'h00_0000, colSel_reg};
    end
    else if (wb_adr_i == `LCDCDL_ADR_COLDATA)
    begin
      readWord = colDataWord;
    end
    else
    begin
      readWord = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      busWait_reg <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      busWait_reg <= busReq & ~busWait_reg;
      wb_ack_o <= busReq & busWait_reg;
      if (busReq & busWait_reg & ~wb_we_i)
      begin
        wb_dat_o <= readWord;
      end
    end
  end

  // column select register, byte lanes 0 and 1
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      colSel_reg <= `LCDCDL_RST_COLSEL;
    end
    else if (busReq & busWait_reg & wb_we_i &&
             wb_adr_i == `LCDCDL_ADR_COLSEL)
    begin
      if (wb_sel_i[0])
      begin
        colSel_reg[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1])
      begin
        colSel_reg[8] <= wb_dat_i[8];
      end
    end
  end

endmodule // lcdcdl_loader

`default_nettype wire

// ==== lcdcdl_loader_props.sv ====
// checker for the column data loader, watching the top level ports
// assumes it is bound onto lcdcdl_loader; everything runs on clk
`timescale 1ns/1ps
`default_nettype none

module lcdcdl_loader_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic shiftDirectionSelect,
  input wire logic startPulseLeftPinOut,
  input wire logic startPulseLeftPinOe,
  input wire logic startPulseRightPinOut,
  input wire logic startPulseRightPinOe,
  input wire logic columnLoadClock,
  input wire logic lineLatchStrobe,
  input wire logic testPin,
  input wire logic ampEnable,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  logic colPrev_reg;
  logic strobeSeen_reg;
  logic [6:0] riseCnt_reg;

  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  always_ff @(posedge clk)
  begin
    colPrev_reg <= columnLoadClock;
  end

  // column clock rises since the last line latch strobe
  always_ff @(posedge clk)
  begin
    if (sys_rst || lineLatchStrobe)
      riseCnt_reg <= 7'h00;
    else if (columnLoadClock && !colPrev_reg && riseCnt_reg != 7'h7f)
      riseCnt_reg <= riseCnt_reg + 7'h01;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      strobeSeen_reg <= 1'b0;
    else if (lineLatchStrobe)
      strobeSeen_reg <= 1'b1;
  end

  property p_right_oe;
    !$past(sys_rst) |-> startPulseRightPinOe == $past(shiftDirectionSelect);
  endproperty
  a_right_oe: assert property (p_right_oe)
    else $error("right start pin enable does not follow direction");

  property p_left_oe;
    !$past(sys_rst) |-> startPulseLeftPinOe == !$past(shiftDirectionSelect);
  endproperty
  a_left_oe: assert property (p_left_oe)
    else $error("left start pin enable does not follow direction");

  property p_right_out;
    startPulseRightPinOut |-> startPulseRightPinOe;
  endproperty
  a_right_out: assert property (p_right_out)
    else $error("pulse on right pin while it is an input");

  property p_left_out;
    startPulseLeftPinOut |-> startPulseLeftPinOe;
  endproperty
  a_left_out: assert property (p_left_out)
    else $error("pulse on left pin while it is an input");

  property p_cascade_count;
    ($rose(startPulseRightPinOut) || $rose(startPulseLeftPinOut))
      |-> riseCnt_reg >= 7'h40;
  endproperty
  a_cascade_count: assert property (p_cascade_count)
    else $error("cascade pulse before 64 column clock rises");

  property p_strobe_clears;
    $rose(lineLatchStrobe)
      |-> ##2 !startPulseRightPinOut && !startPulseLeftPinOut;
  endproperty
  a_strobe_clears: assert property (p_strobe_clears)
    else $error("cascade pulse survives a line latch strobe");

  property p_test_cut;
    $past(testPin) |-> !ampEnable;
  endproperty
  a_test_cut: assert property (p_test_cut)
    else $error("amplifiers enabled in test mode");

  property p_amp_after_strobe;
    ampEnable |-> strobeSeen_reg;
  endproperty
  a_amp_after_strobe: assert property (p_amp_after_strobe)
    else $error("amplifiers enabled before any line latch strobe");

  property p_ack_latency;
    (wb_cyc_i && wb_stb_i && !wb_ack_o && !$past(wb_stb_i))
      |-> ##[2:3] wb_ack_o;
  endproperty
  a_ack_latency: assert property (p_ack_latency)
    else $error("bus acknowledge late");

  c_right_cascade: cover property ($rose(startPulseRightPinOut));
  c_left_cascade: cover property ($rose(startPulseLeftPinOut));
  c_amp_on: cover property ($rose(ampEnable));
endmodule // lcdcdl_loader_props

bind lcdcdl_loader lcdcdl_loader_props i_lcdcdl_loader_props (
  .clk(clk), .sys_rst(sys_rst),
  .shiftDirectionSelect(shiftDirectionSelect),
  .startPulseLeftPinOut(startPulseLeftPinOut),
  .startPulseLeftPinOe(startPulseLeftPinOe),
  .startPulseRightPinOut(startPulseRightPinOut),
  .startPulseRightPinOe(startPulseRightPinOe),
  .columnLoadClock(columnLoadClock), .lineLatchStrobe(lineLatchStrobe),
  .testPin(testPin), .ampEnable(ampEnable), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o)
);
`default_nettype wire

// ==== lcdcdl_tcon_model.sv ====
// timing controller model: start pulse, column clock beats, line strobe
// assumes the bench calls its tasks right after a rising clk edge
`timescale 1ns/1ps
`default_nettype none

module lcdcdl_tcon_model (
  input wire logic clk,
  input wire logic dirSel,
  output logic startLeft,
  output logic startRight,
  output logic colClk,
  output logic strobe,
  output lcdcdl_pkg::lcdcdl_pixel_t pixel
);
  initial
  begin
    startLeft = 1'b0;
    startRight = 1'b0;
    colClk = 1'b0;
    strobe = 1'b0;
    pixel = '0;
  end

  function automatic logic [5:0] pat(input logic [7:0] base, input int idx);
    return 6'(base + 8'(idx * 7));
  endfunction

  // one line of 64 beats; half is the column clock half period in clk
  task automatic line(input logic [7:0] base, input int half,
                      input bit withStart);
    logic [35:0] beat;
    if (withStart)
    begin
      @(posedge clk);
      if (dirSel)
        startLeft <= 1'b1;
      else
        startRight <= 1'b1;
      @(posedge clk);
      startLeft <= 1'b0;
      startRight <= 1'b0;
    end
    @(posedge clk);
    for (int k = 0; k < 64; k++)
    begin
      for (int j = 0; j < 6; j++)
        beat[j*6 +: 6] = pat(base, k * 6 + j);
      pixel <= beat;
      colClk <= 1'b1;
      repeat (half) @(posedge clk);
      colClk <= 1'b0;
      // bus stays busy between beats, never the last value
      pixel <= ~beat;
      repeat (half) @(posedge clk);
    end
    repeat (2) @(posedge clk);
  endtask

  task automatic latch();
    @(posedge clk);
    strobe <= 1'b1;
    repeat (3) @(posedge clk);
    strobe <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
endmodule // lcdcdl_tcon_model
`default_nettype wire

// ==== lcdcdl_loader_test.sv ====
// self-checking bench for the column data loader
// assumes lcdcdl_map.svh on the include path and the tcon model
`timescale 1ns/1ps
`default_nettype none
`include "lcdcdl_map.svh"

module lcdcdl_loader_test;
  logic clk, sys_rst, dirSel, dotSel, invSel, testPin;
  logic cyc, stb, we, ack, amp, tconL, tconR, colClk, strobe;
  logic leftOut, leftOe, rightOut, rightOe, leftPin, rightPin;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, r;
  logic [3:0] pins;
  lcdcdl_pkg::lcdcdl_pixel_t pixel;
  int errorCnt, nCompared;

  assign leftPin = leftOe ? leftOut : tconL;
  assign rightPin = rightOe ? rightOut : tconR;
  assign pins = {rightOut, rightOe, leftOut, leftOe};

  lcdcdl_loader i_lcdcdl_loader (.clk(clk), .sys_rst(sys_rst),
    .shiftDirectionSelect(dirSel), .startPulseLeftPinIn(leftPin),
    .startPulseLeftPinOut(leftOut), .startPulseLeftPinOe(leftOe),
    .startPulseRightPinIn(rightPin), .startPulseRightPinOut(rightOut),
    .startPulseRightPinOe(rightOe), .columnLoadClock(colClk),
    .lineLatchStrobe(strobe), .pixelPort(pixel), .dotSignSelect(dotSel),
    .dataInvertSelect(invSel), .testPin(testPin), .ampEnable(amp),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

  lcdcdl_tcon_model i_lcdcdl_tcon_model (.clk(clk), .dirSel(dirSel),
    .startLeft(tconL), .startRight(tconR), .colClk(colClk),
    .strobe(strobe), .pixel(pixel));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic stopTest();
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    nCompared++;
    if (g !== e)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      errorCnt++;
    end
  endtask

  task automatic wbx(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  // read back sample columns under both dot sign settings
  task automatic cols(input logic [7:0] base, input bit desc,
                      input bit inv, input logic ampExp);
    int list [5] = '{0, 1, 6, 377, 383};
    int k;
    logic [5:0] v;
    logic [8:0] idx;
    for (int i = 0; i < 5; i++)
    begin
      idx = 9'(list[i]);
      k = desc ? 63 - list[i] / 6 : list[i] / 6;
      v = i_lcdcdl_tcon_model.pat(base, k * 6 + list[i] % 6);
      if (inv)
        v = ~v;
      wbx(1'b1, `LCDCDL_ADR_COLSEL, {23'h00_0000, idx}, r);
      for (int d = 0; d < 2; d++)
      begin
        dotSel <= d[0];
        @(posedge clk);
        wbx(1'b0, `LCDCDL_ADR_COLDATA, 32'h0000_0000, r);
        chk(r, {22'h00_0000, ampExp, d[0] ^ idx[0], 2'h0, v});
      end
    end
  endtask

  initial
  begin
    #200000;
    errorCnt++;
    stopTest();
  end

  initial
  begin
    {dirSel, dotSel, invSel, testPin, cyc, stb, we} = 7'h40;
    adr = 8'h00;
    wdat = 32'h0000_0000;
    errorCnt = 0;
    nCompared = 0;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    wbx(1'b0, `LCDCDL_ADR_STATUS, 32'h0000_0000, r);
    chk(r & 32'h0000_0001, 32'h0000_0000);
    chk(32'(amp), 32'h0000_0000);
    i_lcdcdl_tcon_model.latch();
    wbx(1'b0, `LCDCDL_ADR_STATUS, 32'h0000_0000, r);
    chk(r & 32'h0000_0001, 32'h0000_0001);
    i_lcdcdl_tcon_model.line(8'h11, 1, 1'b1);
    chk(32'(pins), 32'h0000_000c);
    wbx(1'b0, `LCDCDL_ADR_STATUS, 32'h0000_0000, r);
    chk(r, 32'h0001_400d);
    i_lcdcdl_tcon_model.latch();
    chk(32'({rightOut, leftOut}), 32'h0000_0000);
    cols(8'h11, 1'b0, 1'b0, 1'b1);
    dirSel <= 1'b0;
    invSel <= 1'b1;
    @(posedge clk);
    i_lcdcdl_tcon_model.line(8'h2a, 2, 1'b1);
    chk(32'(pins), 32'h0000_0003);
    wbx(1'b0, `LCDCDL_ADR_STATUS, 32'h0000_0000, r);
    chk(r, 32'h0000_4005);
    i_lcdcdl_tcon_model.latch();
    cols(8'h2a, 1'b1, 1'b1, 1'b1);
    testPin <= 1'b1;
    invSel <= 1'b0;
    dirSel <= 1'b1;
    @(posedge clk);
    // beats without a start pulse must not load the free bank
    i_lcdcdl_tcon_model.line(8'h33, 1, 1'b0);
    chk(32'({rightOut, leftOut}), 32'h0000_0000);
    wbx(1'b0, `LCDCDL_ADR_STATUS, 32'h0000_0000, r);
    chk(r, 32'h0002_0009);
    i_lcdcdl_tcon_model.latch();
    chk(32'(amp), 32'h0000_0000);
    cols(8'h11, 1'b0, 1'b0, 1'b0);
    wbx(1'b1, 8'h0c, 32'hffff_ffff, r);
    wbx(1'b0, 8'h0c, 32'h0000_0000, r);
    chk(r, 32'h0000_0000);
    stopTest();
  end
endmodule // lcdcdl_loader_test
`default_nettype wire
